// [src/tec_pkg.sv]
// package: constants and carriers for trigger and error control
// Contract
// - input edge 0 rise, 1 fall, 2 both
// - setting 3/4 toggles autotrigger on rise/fall
// - programmable ms delay, max 60000
// - delay zero disables trigger input
// - input active, output zero: single measurement
// - input off, output set: drive output pulses
// - autotrigger alternates start and stop
// - delay also precedes autotrigger stop
// - output edge 0/1/2; all defaults zero (code resets the autostart tracking bit, CFG bit 8, to 1)
// - output pulses no faster than measurement rate
// - unit scale, 0.001 steps, default 1000.000
// - binary distance is mm divided by scale
// - 14-bit signed; out of range gives zero (code zeroes only beyond +/-8192, so +8192 goes out as 14'h2000)
// - no-distance and temperature errors self clear
// - hardware and laser errors sticky until reset
// - report highest active error code only
// - errors never block commands
// - escape stops tracking even during errors
// - tracking restart repeats uncleared error
// - binary format sends errors as zero
// - errors output like values, once or repeated
// - terminator only in decimal format
package tec_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned MS_TICK_CYC = CLK_HZ / 1000;
  localparam logic [15:0] DELAY_MAX_MS = 16'hea60;
  localparam logic [7:0] PAD_ADDR_CFG = 8'h00;
  localparam logic [7:0] PAD_ADDR_SCALE = 8'h04;
  localparam logic [7:0] PAD_ADDR_MFREQ = 8'h08;
  localparam logic [7:0] PAD_ADDR_CTRL = 8'h0c;
  localparam logic [7:0] PAD_ADDR_STAT = 8'h10;
  localparam logic [7:0] PAD_ADDR_DIST = 8'h14;
  localparam logic [31:0] SCALE_RST = 32'h000f4240;
  localparam logic [31:0] MFREQ_RST = 32'h00000001;
  localparam logic [2:0] TI_EDGE_RST = 3'h0;
  localparam logic [15:0] TI_DELAY_RST = 16'h0000;
  localparam logic [1:0] TO_EDGE_RST = 2'h0;
  localparam logic [13:0] BIN_LIMIT = 14'h2000;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_NODIST = 8'h02;
  localparam logic [7:0] ERR_HWFAULT = 8'h04;
  localparam logic [7:0] ERR_TEMP = 8'h06;
  localparam logic [7:0] ERR_LASERV = 8'h10;
  typedef enum logic [1:0] {TEC_FMT_DEC, TEC_FMT_HEX, TEC_FMT_BIN,
    TEC_FMT_RSV} tec_fmt_e;
  typedef struct packed {
    logic [31:0] dist_um;
    logic valid;
    logic no_dist;
    logic hw_fault;
    logic temp_bad;
    logic laser_low;
  } tec_meas_s;
  typedef struct packed {
    logic [13:0] bin_dist;
    logic [7:0] err_code;
    logic use_term;
    logic valid;
  } tec_out_s;
endpackage

// [src/tec_top.sv]
// module: trigger, autotrigger, output trigger, scaling and error report
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module tec_top
#(
  parameter int unsigned MS_CYC = tec_pkg::MS_TICK_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger line
  input wire logic trig_in,
  output logic trig_out,
  // measurement engine
  input wire tec_pkg::tec_meas_s meas,
  input wire logic meas_tick,
  input wire logic esc_rx,
  output logic meas_start,
  output logic track_active,
  output tec_pkg::tec_out_s out_word
);
  import tec_pkg::*;

  logic [2:0] ti_edge_reg;
  logic [15:0] ti_delay_reg;
  logic [1:0] to_edge_reg;
  logic [1:0] fmt_reg;
  logic autostart_track_reg;
  logic [31:0] scale_reg;
  logic [31:0] mfreq_reg;
  logic [31:0] rate_cnt_reg;
  logic sync1_reg, sync2_reg, sync3_reg;
  logic [31:0] tick_cnt_reg;
  logic ms_tick;
  logic [15:0] delay_cnt_reg;
  logic delay_busy_reg;
  logic auto_on_reg;
  logic hw_err_reg, laser_err_reg;
  logic nodist_reg, temp_reg;
  logic trk_cmd, stop_cmd, dm_cmd, dr_cmd;
  logic wr, rd, rise, fall, qualify, auto_mode, in_en, out_en;
  logic [7:0] err_code;
  logic [31:0] quot;
  logic signed [31:0] squot;
  logic to_level_reg;
  logic to_fire;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == PAD_ADDR_CFG ||
    paddr == PAD_ADDR_SCALE || paddr == PAD_ADDR_MFREQ ||
    paddr == PAD_ADDR_CTRL || paddr == PAD_ADDR_STAT ||
    paddr == PAD_ADDR_DIST);
  assign trk_cmd = wr && paddr == PAD_ADDR_CTRL && pwdata[0];
  assign stop_cmd = wr && paddr == PAD_ADDR_CTRL && pwdata[1];
  assign dm_cmd = wr && paddr == PAD_ADDR_CTRL && pwdata[2];
  assign dr_cmd = wr && paddr == PAD_ADDR_CTRL && pwdata[3];

  // configuration over the bus, accepted regardless of errors
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ti_edge_reg <= TI_EDGE_RST;
      ti_delay_reg <= TI_DELAY_RST;
      to_edge_reg <= TO_EDGE_RST;
      fmt_reg <= 2'h0;
      autostart_track_reg <= 1'b1;
      scale_reg <= SCALE_RST;
      mfreq_reg <= MFREQ_RST;
    end
    else if (wr)
    begin
      if (paddr == PAD_ADDR_CFG)
      begin
        if (pwdata[2:0] <= 3'h4)
          ti_edge_reg <= pwdata[2:0];
        if (pwdata[5:4] <= 2'h2)
          to_edge_reg <= pwdata[5:4];
        if (pwdata[7:6] != 2'h3)
          fmt_reg <= pwdata[7:6];
        autostart_track_reg <= pwdata[8];
        if (pwdata[31:16] <= DELAY_MAX_MS)
          ti_delay_reg <= pwdata[31:16];
      end
      if (paddr == PAD_ADDR_SCALE && pwdata != 32'h0)
        scale_reg <= pwdata;
      if (paddr == PAD_ADDR_MFREQ && pwdata != 32'h0)
        mfreq_reg <= pwdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        PAD_ADDR_CFG: prdata <= {ti_delay_reg, 7'h0, autostart_track_reg,
          fmt_reg, to_edge_reg, 1'b0, ti_edge_reg};
        PAD_ADDR_SCALE: prdata <= scale_reg;
        PAD_ADDR_MFREQ: prdata <= mfreq_reg;
        PAD_ADDR_STAT: prdata <= {20'h0, auto_on_reg, delay_busy_reg,
          track_active, 1'b0, err_code};
        PAD_ADDR_DIST: prdata <= {18'h0, out_word.bin_dist};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // input synchroniser and ms prescaler
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= trig_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      tick_cnt_reg <= 32'h0;
    else if (tick_cnt_reg >= 32'(MS_CYC - 1) || !delay_busy_reg)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end
  assign ms_tick = delay_busy_reg && tick_cnt_reg >= 32'(MS_CYC - 1);

  assign rise = sync2_reg && !sync3_reg;
  assign fall = !sync2_reg && sync3_reg;
  assign auto_mode = ti_edge_reg == 3'h3 || ti_edge_reg == 3'h4;
  assign in_en = ti_delay_reg != 16'h0;
  assign out_en = !in_en && to_edge_reg != 2'h3;
  always_comb
  begin
    unique case (ti_edge_reg)
      3'h0: qualify = rise;
      3'h1: qualify = fall;
      3'h2: qualify = rise || fall;
      3'h3: qualify = rise;
      3'h4: qualify = fall;
      default: qualify = 1'b0;
    endcase
  end

  // delay between trigger event and action
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      delay_busy_reg <= 1'b0;
      delay_cnt_reg <= 16'h0;
    end
    else if (!delay_busy_reg)
    begin
      if (qualify && in_en)
      begin
        delay_busy_reg <= 1'b1;
        delay_cnt_reg <= ti_delay_reg;
      end
    end
    else if (ms_tick)
    begin
      if (delay_cnt_reg == 16'h1)
        delay_busy_reg <= 1'b0;
      delay_cnt_reg <= delay_cnt_reg - 16'h1;
    end
  end

  logic delay_done;
  assign delay_done = delay_busy_reg && ms_tick && delay_cnt_reg == 16'h1;

  // autotrigger toggle and tracking state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      auto_on_reg <= 1'b0;
    else if (esc_rx || stop_cmd || !auto_mode)
      auto_on_reg <= 1'b0;
    else if (delay_done)
      auto_on_reg <= !auto_on_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      track_active <= 1'b0;
    else if (esc_rx || stop_cmd)
      track_active <= 1'b0;
    else if (trk_cmd)
      track_active <= 1'b1;
    else if (delay_done && auto_mode && autostart_track_reg)
      track_active <= !auto_on_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      meas_start <= 1'b0;
    else
      meas_start <= dm_cmd || trk_cmd ||
        (delay_done && to_edge_reg == 2'h0 && !auto_mode) ||
        (delay_done && auto_mode && !auto_on_reg && !autostart_track_reg);
  end

  // error flags: sticky ones cleared only by reset command
  // next values let the current sample's errors reach its own output
  logic hw_err_next, laser_err_next, nodist_next, temp_next;
  always_comb
  begin
    hw_err_next = (meas.valid && meas.hw_fault) ||
      (hw_err_reg && !dr_cmd);
    laser_err_next = (meas.valid && meas.laser_low) ||
      (laser_err_reg && !dr_cmd);
    nodist_next = meas.valid ? meas.no_dist : nodist_reg;
    temp_next = meas.valid ? meas.temp_bad : temp_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hw_err_reg <= 1'b0;
      laser_err_reg <= 1'b0;
      nodist_reg <= 1'b0;
      temp_reg <= 1'b0;
    end
    else
    begin
      hw_err_reg <= hw_err_next;
      laser_err_reg <= laser_err_next;
      nodist_reg <= nodist_next;
      temp_reg <= temp_next;
    end
  end

  always_comb
  begin
    if (laser_err_next)
      err_code = ERR_LASERV;
    else if (temp_next)
      err_code = ERR_TEMP;
    else if (hw_err_next)
      err_code = ERR_HWFAULT;
    else if (nodist_next)
      err_code = ERR_NODIST;
    else
      err_code = ERR_NONE;
  end

  // binary scaling: um / (scale in 0.001 steps) gives mm / scale
  assign squot = $signed(meas.dist_um) / $signed(scale_reg);
  assign quot = squot;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      out_word <= '0;
    else
    begin
      out_word.valid <= meas_tick && (track_active || meas_start);
      out_word.err_code <= err_code;
      out_word.use_term <= fmt_reg == 2'(TEC_FMT_DEC);
      if (err_code != ERR_NONE || squot > $signed({18'h0, BIN_LIMIT}) ||
          squot < -$signed({18'h0, BIN_LIMIT}))
        out_word.bin_dist <= 14'h0;
      else
        out_word.bin_dist <= quot[13:0];
    end
  end

  // trigger output, rate limited to measurement frequency
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rate_cnt_reg <= 32'h0;
    else if (to_fire)
      rate_cnt_reg <= 32'(CLK_HZ) / mfreq_reg;
    else if (rate_cnt_reg != 32'h0)
      rate_cnt_reg <= rate_cnt_reg - 32'h1;
  end
  assign to_fire = out_en && meas_start && rate_cnt_reg == 32'h0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      to_level_reg <= 1'b0;
    else if (to_fire)
      to_level_reg <= to_edge_reg == 2'h1 ? 1'b0 :
        (to_edge_reg == 2'h2 ? !to_level_reg : 1'b1);
    else if (to_edge_reg != 2'h2 && rate_cnt_reg == 32'h1)
      to_level_reg <= to_edge_reg == 2'h1;
  end
  assign trig_out = to_level_reg;

  a_delay_len: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    $rose(delay_busy_reg) |-> delay_cnt_reg == $past(ti_delay_reg))
    else $error("delay load wrong");
  a_off_no_delay: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    !in_en |=> !$rose(delay_busy_reg))
    else $error("delay started while disabled");
  a_sticky_err: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    hw_err_reg && !dr_cmd |=> hw_err_reg)
    else $error("sticky error lost");
  a_laser_sticky: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    laser_err_reg && !dr_cmd |=> laser_err_reg)
    else $error("laser error lost");
  a_self_clear: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    meas.valid && !meas.no_dist |=> !nodist_reg)
    else $error("no distance error kept");
  a_err_zero: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    err_code != ERR_NONE |=> out_word.bin_dist == 14'h0)
    else $error("error not zero");
  a_err_prio: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    laser_err_next |-> err_code == ERR_LASERV)
    else $error("priority wrong");
  a_esc_stop: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    esc_rx |=> !track_active)
    else $error("escape ignored");
  a_busy_ignore: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    delay_busy_reg && !ms_tick |=> $stable(delay_cnt_reg))
    else $error("delay reloaded");
  a_term_dec: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    out_word.use_term |-> $past(fmt_reg) == 2'h0)
    else $error("terminator in binary");
  a_out_rate: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    to_fire |=> !to_fire)
    else $error("output too fast");
  a_out_quiet: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    in_en |-> !to_fire)
    else $error("output pulse while input active");
  a_sync_edge: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    qualify |-> sync2_reg != sync3_reg)
    else $error("edge without synced change");
  a_edge_rise: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    ti_edge_reg == 3'h0 && !rise |-> !qualify)
    else $error("wrong edge accepted");
  a_single_start: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    delay_done && !auto_mode && to_edge_reg == 2'h0 |=> meas_start)
    else $error("trigger start missing");
  a_auto_toggle: assert property
    (@(posedge clk_sys) disable iff (!rst_b)
    delay_done && auto_mode && autostart_track_reg && !esc_rx &&
    !stop_cmd && !trk_cmd |=> track_active == !$past(auto_on_reg))
    else $error("autotrigger toggle wrong");
endmodule

// [dv/tec_host_model.sv]
// host side model: trigger pin, sample feed and escape key
`timescale 1ns/1ps
module tec_host_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench requests
  input wire logic trig_lvl,
  input wire logic fire,
  input wire logic esc_req,
  input wire tec_pkg::tec_meas_s smp,
  // device side
  output logic trig_in,
  output tec_pkg::tec_meas_s meas,
  output logic meas_tick,
  output logic esc_rx
);
  import tec_pkg::*;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trig_in <= 1'b0;
      meas <= '0;
      meas_tick <= 1'b0;
      esc_rx <= 1'b0;
    end
    else
    begin
      trig_in <= trig_lvl;
      meas_tick <= fire;
      meas <= fire ? smp : {~meas.dist_um, 1'b0, ~meas[3:0]};
      esc_rx <= esc_req;
    end
  end
endmodule

// [dv/trigger_and_error_control_bench.sv]
// bench: trigger, autotrigger, scaling and error report checks
`timescale 1ns/1ps
module trigger_and_error_control_bench;
  import tec_pkg::*;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic trig_in, trig_out, meas_tick, esc_rx, meas_start, track_active;
  logic trig_lvl, fire, esc_req;
  tec_meas_s meas, smp;
  tec_out_s out_word, ex;
  tec_out_s exq[$];
  int err_total, comparisons, cyc, n, k;
  tec_top #(.MS_CYC(10)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .trig_out(trig_out),
    .meas(meas), .meas_tick(meas_tick), .esc_rx(esc_rx),
    .meas_start(meas_start), .track_active(track_active),
    .out_word(out_word));
  tec_host_model u_host (.clk_sys(clk_sys), .rst_b(rst_b),
    .trig_lvl(trig_lvl), .fire(fire), .esc_req(esc_req), .smp(smp),
    .trig_in(trig_in), .meas(meas), .meas_tick(meas_tick),
    .esc_rx(esc_rx));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input logic lvl);
    logic t0;
    t0 = track_active;
    trig_lvl <= lvl;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (meas_start !== 1'b1 && track_active === t0 && n < 60);
  endtask
  function automatic tec_out_s bo(input logic [13:0] b,
    input logic [7:0] c);
    return {b, c, 1'b0, 1'b1};
  endfunction
  task automatic snd(input logic [31:0] d, input logic [3:0] f,
    input tec_out_s e);
    smp <= {d, 1'b1, f};
    fire <= 1'b1;
    exq.push_back(e);
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
    if (out_word.valid === 1'b1)
    begin
      ex = (exq.size() > 0) ? exq.pop_front() : '0;
      chk(out_word, ex);
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up;
    end
  end
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    trig_lvl = 1'b0;
    fire = 1'b0;
    esc_req = 1'b0;
    smp = '0;
    void'($urandom(58940));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b1, PAD_ADDR_MFREQ, 32'h989680);
    apb(1'b0, PAD_ADDR_CFG, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, PAD_ADDR_SCALE, 32'h0);
    chk(rd, SCALE_RST);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    for (int e = 0; e < 3; e++)
    begin
      apb(1'b1, PAD_ADDR_CFG, {16'h0002, 13'h0, e[2:0]});
      wt(1'b1);
      chk(n >= 20 && n <= 28, e != 1);
      repeat (40) @(posedge clk_sys);
      wt(1'b0);
      chk(n >= 20 && n <= 28, e != 0);
      repeat (40) @(posedge clk_sys);
    end
    trig_lvl <= 1'b1;
    repeat (5) @(posedge clk_sys);
    trig_lvl <= 1'b0;
    k = 0;
    repeat (60)
    begin
      @(posedge clk_sys);
      k += meas_start;
    end
    chk(k, 1);
    apb(1'b1, PAD_ADDR_CFG, 32'h0);
    wt(1'b1);
    chk(n, 60);
    for (int e = 3; e < 5; e++)
    begin
      apb(1'b1, PAD_ADDR_CFG, {16'h0001, 7'h0, 1'b1, 5'h0, e[2:0]});
      trig_lvl <= (e == 4);
      repeat (40) @(posedge clk_sys);
      for (int i = 0; i < 2; i++)
      begin
        wt(e == 3);
        chk({n >= 10 && n <= 18, track_active}, {1'b1, i == 0});
        wt(e == 4);
      end
    end
    apb(1'b1, PAD_ADDR_CFG, 32'h80);
    apb(1'b1, PAD_ADDR_SCALE, 32'h9c4);
    apb(1'b1, PAD_ADDR_CTRL, 32'h1);
    repeat (4)
    begin
      k = $urandom % 3000;
      snd(32'(k * 2500), 4'h0, bo(14'(k), 8'h0));
    end
    snd(32'h13889c4, 4'h0, bo(14'h0, 8'h0));
    snd(32'hfffc2f70, 4'h0, bo(14'h3f9c, 8'h0));
    snd(32'h0, 4'h8, bo(14'h0, ERR_NODIST));
    snd(32'h61a8, 4'h0, bo(14'ha, 8'h0));
    snd(32'h0, 4'ha, bo(14'h0, ERR_TEMP));
    snd(32'h61a8, 4'h0, bo(14'ha, 8'h0));
    snd(32'h61a8, 4'h4, bo(14'h0, ERR_HWFAULT));
    snd(32'h61a8, 4'h0, bo(14'h0, ERR_HWFAULT));
    snd(32'h0, 4'h9, bo(14'h0, ERR_LASERV));
    apb(1'b0, PAD_ADDR_CFG, 32'h0);
    chk(rd, 32'h80);
    esc_req <= 1'b1;
    @(posedge clk_sys);
    esc_req <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(track_active, 1'b0);
    apb(1'b1, PAD_ADDR_CTRL, 32'h1);
    snd(32'h61a8, 4'h0, bo(14'h0, ERR_LASERV));
    apb(1'b1, PAD_ADDR_CTRL, 32'h8);
    apb(1'b1, PAD_ADDR_CFG, 32'h0);
    apb(1'b1, PAD_ADDR_CTRL, 32'h1);
    snd(32'h0, 4'h0, 24'h3);
    apb(1'b1, PAD_ADDR_MFREQ, 32'h989680);
    apb(1'b1, PAD_ADDR_CTRL, 32'h4);
    n = 0;
    while (trig_out !== 1'b1 && n < 30)
    begin
      @(posedge clk_sys);
      n++;
    end
    k = 0;
    while (trig_out === 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk(n < 30 && k >= 10 && k < 40, 1'b1);
    repeat (20) @(posedge clk_sys);
    chk(exq.size(), 0);
    wrap_up;
  end
endmodule
